// *** rtl/uart_serial_port.sv ***
// Purpose: full-duplex asynchronous serial port with APB registers
// Assumes: one clock, async active-high reset, serial_in asynchronous
// Notes: parity replaces the top data bit; receiver checks the first stop bit
// Summary of operation
// - frames carry 8 or 9 data bits chosen by char_length_select
// - even, odd or no parity, then one or two stop bits
// - shared bit timing comes from an 8-bit programmable baud divisor
// - received characters wait in a two-entry buffer
// - written character moves to a transmit shifter, sent LSB first
// - receive shifter fills LSB first, whole character goes to buffer
// - one data address: write sends, read returns oldest character
// - disabled port or transmitter leaves serial_out undriven; receiver enable does not gate it
// - status is read-only; idle flags and transmit-empty reset to one
// - bit 7 flags parity mismatch only while parity is enabled
// - bit 6 flags noise with receive-full, never on overrun
// - bit 5 flags a framing error on the current character
// - bit 4 flags overrun and blocks further transfers into the buffer
// - bit 3 is zero from start detection until stop bit ends
// - bit 2 set when a character enters the buffer, with errors
// - receive-full clears after status read, data read, empty buffer
// - bit 1 set when nothing is queued or sent; line idles high
// - transmitter-idle clears on status read then data write
// - bit 0 set on move to shifter; clears on status read then write
// - enabling the transmitter sets transmit-empty
// - interrupts for empty, idle, full, overrun and wake-up
// - with address detect, only characters with top bit one are kept
// - port disable flushes, resets counters, flags and enables
// - ninth bit is sent from transmit_ninth_bit, kept in received_ninth_bit
// - parity_type zero selects even parity, one selects odd
`timescale 1ns/1ps
module uart_serial_port
   import uart_serial_port_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   output logic uart_irq
);
   status_type stat;
   status_type next_stat;
   logic [7:0] armed;
   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [7:0] baud;
   logic [7:0] baud_cnt;
   logic [1:0] rx_sync;
   logic rx_prev;
   logic tx_on_prev;
   logic wake_pend;
   tx_state_type tx_state;
   logic [8:0] tx_hold;
   logic tx_full;
   logic [11:0] tx_shift;
   logic [3:0] tx_phase;
   logic [3:0] tx_left;
   rx_state_type rx_state;
   rx_state_type next_rx_state;
   logic [3:0] rx_phase;
   logic [3:0] rx_left;
   logic [8:0] rx_shift;
   logic [2:0] votes;
   logic rx_noise;
   logic [8:0] fifo_mem [0:1];
   logic fifo_wr;
   logic fifo_rd;
   logic [1:0] fifo_count;

   // bus decode
   wire access = psel & penable;
   wire done = access & pready;
   wire wr = done & pwrite;
   wire rd = done & ~pwrite;
   wire sel_status = paddr == ADDR_STATUS;
   wire sel_ca = paddr == ADDR_CONTROL_A;
   wire sel_cb = paddr == ADDR_CONTROL_B;
   wire sel_data = paddr == ADDR_DATA;
   wire sel_baud = paddr == ADDR_BAUD;
   wire mapped = sel_status | sel_ca | sel_cb | sel_data | sel_baud;
   wire status_rd = rd & sel_status;
   wire data_wr = wr & sel_data;
   wire data_rd = rd & sel_data;
   wire data_any = done & sel_data;

   // configuration view
   wire port_en = ctrl_a[CA_PORT_ENABLE];
   wire nine = ctrl_a[CA_CHAR_LENGTH];
   wire parity_enable = ctrl_a[CA_PARITY_ENABLE];
   wire parity_type = ctrl_a[CA_PARITY_TYPE];
   wire tx_on = port_en & ctrl_b[CB_TRANSMIT_ENABLE];
   wire rx_on = port_en & ctrl_b[CB_RECEIVE_ENABLE];
   wire tx_on_rise = tx_on & ~tx_on_prev;
   wire [8:0] fifo_head = fifo_mem[fifo_rd];
   wire [7:0] next_ctrl_a = (wr & sel_ca) ? (pwdata[7:0] & CONTROL_A_WRITE_MASK) : ctrl_a;
   wire [7:0] next_ctrl_b = (wr & sel_cb) ? pwdata[7:0] : ctrl_b;

   // read data selection
   wire [7:0] ca_view = {ctrl_a[7:2], fifo_head[8], 1'b0};
   wire [7:0] read_byte = sel_status ? stat :
                          sel_ca ? ca_view :
                          sel_cb ? ctrl_b :
                          sel_data ? fifo_head[7:0] :
                          sel_baud ? baud : CONTROL_RESET;

   // baud tick generator
   wire baud_tick = baud_cnt == baud;

   // transmit framing
   wire [8:0] tx_char = nine ? {tx_hold[8] ^ (parity_enable & ((^tx_hold) ^ parity_type)), tx_hold[7:0]} :
                        {1'b1, tx_hold[7] ^ (parity_enable & ((^tx_hold[7:0]) ^ parity_type)), tx_hold[6:0]};
   wire [11:0] tx_frame = {2'b11, tx_char, 1'b0};
   wire [3:0] tx_frame_last = FRAME_LAST_BASE + {3'b000, nine} + {3'b000, ctrl_a[CA_STOP_COUNT]};
   wire load = tx_on & tx_full & (tx_state == TX_IDLE);
   wire break_go = tx_on & ~tx_full & (tx_state == TX_IDLE) & ctrl_a[CA_SEND_BREAK];
   wire tx_bit_end = baud_tick & (tx_phase == PHASE_LAST);

   // receive sampling
   wire rx_in = rx_sync[1];
   wire majority = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
   wire noisy = ~(&votes) & (|votes);
   wire rx_bit_end = baud_tick & (rx_phase == PHASE_LAST);
   wire vote_now = baud_tick & (rx_phase >= VOTE_FIRST) & (rx_phase <= VOTE_LAST);
   wire rx_done = rx_on & (rx_state == RX_STOP) & rx_bit_end;
   wire [8:0] rx_char = nine ? rx_shift : {1'b0, rx_shift[8:1]};
   wire addr_bit = nine ? rx_char[8] : rx_char[7];
   wire keep = ~(ctrl_b[CB_ADDRESS_DETECT] & ~addr_bit);
   wire push = rx_done & keep & ~stat.overrun_flag & (fifo_count != FIFO_DEPTH);
   wire overrun_set = rx_done & keep & ~stat.overrun_flag & (fifo_count == FIFO_DEPTH);
   wire pop = data_rd & (fifo_count != 2'h0);
   wire parity_error_flag_calc = parity_enable & ((^rx_char) != parity_type);
   wire wake_event = ctrl_b[CB_WAKE_ENABLE] & (rx_state == RX_IDLE) & rx_prev & ~rx_in;

   // flag clears after a status read
   wire [7:0] clr_any = armed & {8{data_any}};
   wire receive_full_flag_clr = armed[2] & data_rd & (fifo_count == 2'h1);
   wire tx_clr = data_wr;

   always_comb begin
      next_rx_state = rx_state;
      if (!rx_on) begin
         next_rx_state = RX_IDLE;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               if (!rx_in) begin
                  next_rx_state = RX_START;
               end
            end
            RX_START: begin
               if (rx_bit_end) begin
                  next_rx_state = majority ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_bit_end && rx_left == 4'h0) begin
                  next_rx_state = RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_bit_end) begin
                  next_rx_state = RX_IDLE;
               end
            end
            default: next_rx_state = RX_IDLE;
         endcase
      end
   end

   always_comb begin
      next_stat = stat;
      next_stat.receiver_idle_flag = next_rx_state == RX_IDLE;
      if (!port_en) begin
         next_stat = status_type'(STATUS_RESET);
      end else begin
         next_stat.parity_error_flag = (push & parity_error_flag_calc) | (stat.parity_error_flag & ~clr_any[7]);
         next_stat.noise_flag = (push & (rx_noise | noisy)) | (stat.noise_flag & ~clr_any[6]);
         next_stat.framing_error_flag = (push & ~majority) | (stat.framing_error_flag & ~clr_any[5]);
         next_stat.overrun_flag = overrun_set | (stat.overrun_flag & ~clr_any[4]);
         next_stat.receive_full_flag = push | (stat.receive_full_flag & ~receive_full_flag_clr);
         next_stat.transmitter_idle_flag = (stat.transmit_empty_flag & ~tx_full & ~data_wr & (tx_state == TX_IDLE)
            & ~ctrl_a[CA_SEND_BREAK]) | (stat.transmitter_idle_flag & ~(armed[1] & tx_clr));
         next_stat.transmit_empty_flag = load | tx_on_rise
            | (stat.transmit_empty_flag & ~(armed[0] & tx_clr));
      end
   end

   // bus slave
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access & ~pready;
         if (access && !pready) begin
            pslverr <= ~mapped;
            prdata <= {READ_PAD, read_byte};
         end
      end
   end

   // registers and sticky status
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_a <= CONTROL_RESET;
         ctrl_b <= CONTROL_RESET;
         baud <= BAUD_RESET;
         stat <= status_type'(STATUS_RESET);
         armed <= 8'h00;
         tx_on_prev <= 1'b0;
         wake_pend <= 1'b0;
         uart_irq <= 1'b0;
      end else begin
         ctrl_a <= {next_ctrl_a[7:3], next_ctrl_a[2] & next_ctrl_a[CA_PORT_ENABLE], next_ctrl_a[1:0]};
         ctrl_b <= {next_ctrl_b[7:6] & {2{next_ctrl_a[CA_PORT_ENABLE]}}, next_ctrl_b[5:0]};
         if (wr && sel_baud) begin
            baud <= pwdata[7:0];
         end
         stat <= next_stat;
         armed <= status_rd ? prdata[7:0] : (data_any ? 8'h00 : armed);
         tx_on_prev <= tx_on;
         wake_pend <= wake_event | (wake_pend & ~status_rd & ctrl_b[CB_WAKE_ENABLE]);
         uart_irq <= (ctrl_b[CB_RECEIVE_IRQ] & (stat.receive_full_flag | stat.overrun_flag))
            | (ctrl_b[CB_IDLE_IRQ] & stat.transmitter_idle_flag)
            | (ctrl_b[CB_EMPTY_IRQ] & stat.transmit_empty_flag) | wake_pend;
      end
   end

   // baud counter
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         baud_cnt <= BAUD_RESET;
      end else begin
         baud_cnt <= (!port_en || baud_tick) ? BAUD_RESET : baud_cnt + 8'h01;
      end
   end

   // transmitter
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tx_state <= TX_IDLE;
         tx_hold <= 9'h000;
         tx_full <= 1'b0;
         tx_shift <= 12'hFFF;
         tx_phase <= 4'h0;
         tx_left <= 4'h0;
         serial_out <= 1'b1;
         serial_out_oe <= 1'b0;
      end else begin
         serial_out_oe <= tx_on;
         serial_out <= (tx_state == TX_SHIFT) ? tx_shift[0] : (tx_state != TX_BREAK);
         if (baud_tick) begin
            tx_phase <= tx_phase + 4'h1;
         end
         if (!tx_on) begin
            tx_state <= TX_IDLE;
            tx_full <= 1'b0;
            tx_phase <= 4'h0;
         end else begin
            if (data_wr) begin
               tx_hold <= {ctrl_a[CA_NINTH_BIT], pwdata[7:0]};
               tx_full <= 1'b1;
            end else if (load) begin
               tx_full <= 1'b0;
            end
            case (tx_state)
               TX_IDLE: begin
                  tx_phase <= 4'h0;
                  if (load) begin
                     tx_shift <= tx_frame;
                     tx_left <= tx_frame_last;
                     tx_state <= TX_SHIFT;
                  end else if (break_go) begin
                     tx_left <= BREAK_LAST;
                     tx_state <= TX_BREAK;
                  end
               end
               TX_SHIFT: begin
                  if (tx_bit_end) begin
                     tx_shift <= {1'b1, tx_shift[11:1]};
                     tx_left <= tx_left - 4'h1;
                     if (tx_left == 4'h0) begin
                        tx_state <= TX_IDLE;
                     end
                  end
               end
               TX_BREAK: begin
                  if (tx_bit_end) begin
                     if (tx_left != 4'h0) begin
                        tx_left <= tx_left - 4'h1;
                     end else if (!ctrl_a[CA_SEND_BREAK]) begin
                        tx_state <= TX_IDLE;
                     end
                  end
               end
               default: tx_state <= TX_IDLE;
            endcase
         end
      end
   end

   // receiver
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rx_sync <= 2'b11;
         rx_prev <= 1'b1;
         rx_state <= RX_IDLE;
         rx_phase <= 4'h0;
         rx_left <= 4'h0;
         rx_shift <= 9'h000;
         votes <= 3'b111;
         rx_noise <= 1'b0;
      end else begin
         rx_sync <= {rx_sync[0], serial_in};
         rx_prev <= rx_in;
         rx_state <= next_rx_state;
         if (rx_state == RX_IDLE) begin
            rx_phase <= 4'h0;
            rx_noise <= 1'b0;
            rx_left <= nine ? DATA_LAST_9 : DATA_LAST_8;
         end else if (baud_tick) begin
            rx_phase <= rx_phase + 4'h1;
         end
         if (vote_now) begin
            votes <= {votes[1:0], rx_in};
         end
         if (rx_bit_end && rx_state != RX_IDLE) begin
            rx_noise <= rx_noise | noisy;
         end
         if (rx_bit_end && rx_state == RX_DATA) begin
            rx_shift <= {majority, rx_shift[8:1]};
            rx_left <= rx_left - 4'h1;
         end
      end
   end

   // two-entry receive buffer
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fifo_wr <= 1'b0;
         fifo_rd <= 1'b0;
         fifo_count <= 2'h0;
      end else if (!rx_on) begin
         fifo_wr <= 1'b0;
         fifo_rd <= 1'b0;
         fifo_count <= 2'h0;
      end else begin
         if (push) begin
            fifo_wr <= ~fifo_wr;
         end
         if (pop) begin
            fifo_rd <= ~fifo_rd;
         end
         fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
      end
   end

   genvar entry;
   generate
      for (entry = 0; entry < 2; entry++) begin : g_entry
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               fifo_mem[entry] <= 9'h000;
            end else if (push && fifo_wr == entry[0]) begin
               fifo_mem[entry] <= rx_char;
            end
         end
      end
   endgenerate

   // checks
   property p_pin_release;
      @(posedge clk_sys) disable iff (reset) !tx_on |=> !serial_out_oe;
   endproperty
   a_pin_release: assert property (p_pin_release) else $error("tx pin driven while disabled");

   property p_overrun_blocks;
      @(posedge clk_sys) disable iff (reset) stat.overrun_flag |-> !push;
   endproperty
   a_overrun_blocks: assert property (p_overrun_blocks) else $error("push during overrun");

   property p_push_full;
      @(posedge clk_sys) disable iff (reset) push |=> stat.receive_full_flag && fifo_count != 2'h0;
   endproperty
   a_push_full: assert property (p_push_full) else $error("receive-full not set on push");

   property p_receiver_idle_flag;
      @(posedge clk_sys) disable iff (reset) stat.receiver_idle_flag == (rx_state == RX_IDLE);
   endproperty
   a_receiver_idle_flag: assert property (p_receiver_idle_flag) else $error("receiver idle flag mismatch");

   property p_disable;
      @(posedge clk_sys) disable iff (reset)
         !port_en |=> stat.transmitter_idle_flag && stat.transmit_empty_flag && !stat.overrun_flag;
   endproperty
   a_disable: assert property (p_disable) else $error("flags not reset on disable");

   property p_receive_full_flag_hold;
      @(posedge clk_sys) disable iff (reset) (data_rd && fifo_count == FIFO_DEPTH && rx_on) |=> stat.receive_full_flag;
   endproperty
   a_receive_full_flag_hold: assert property (p_receive_full_flag_hold) else $error("receive-full lost with data left");

   property p_idle_high;
      @(posedge clk_sys) disable iff (reset) (tx_on && tx_state == TX_IDLE)[*2] |=> serial_out;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle line not high");

   property p_transmit_enable_sets_empty;
      @(posedge clk_sys) disable iff (reset) tx_on_rise |=> stat.transmit_empty_flag;
   endproperty
   a_transmit_enable_sets_empty: assert property (p_transmit_enable_sets_empty) else $error("enable did not set empty");

   property p_empty_clear;
      @(posedge clk_sys) disable iff (reset)
         (data_wr && armed[0] && !load && !tx_on_rise && port_en) |=> !stat.transmit_empty_flag;
   endproperty
   a_empty_clear: assert property (p_empty_clear) else $error("empty flag not cleared");

   property p_parity_off;
      @(posedge clk_sys) disable iff (reset) (push && !parity_enable && !stat.parity_error_flag) |=> !stat.parity_error_flag;
   endproperty
   a_parity_off: assert property (p_parity_off) else $error("parity error with parity off");

   c_push: cover property (@(posedge clk_sys) disable iff (reset) push);
   c_overrun: cover property (@(posedge clk_sys) disable iff (reset) overrun_set);
   c_load: cover property (@(posedge clk_sys) disable iff (reset) load);
   c_break: cover property (@(posedge clk_sys) disable iff (reset) tx_state == TX_BREAK);
endmodule // uart_serial_port

// *** rtl/uart_serial_port_pkg.sv ***
// Purpose: constants and types for the serial port block
// Assumes: APB register access, 32-bit data, 16 baud ticks per bit
// Notes: byte offsets are chosen locally
package uart_serial_port_pkg;
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_A = 8'h04;
   localparam logic [7:0] ADDR_CONTROL_B = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0C;
   localparam logic [7:0] ADDR_BAUD = 8'h10;
   localparam logic [7:0] STATUS_RESET = 8'h0B;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [7:0] CONTROL_A_WRITE_MASK = 8'hFD;
   localparam logic [23:0] READ_PAD = 24'h000000;
   // uart_control_a fields
   localparam int unsigned CA_PORT_ENABLE = 7;
   localparam int unsigned CA_CHAR_LENGTH = 6;
   localparam int unsigned CA_PARITY_ENABLE = 5;
   localparam int unsigned CA_PARITY_TYPE = 4;
   localparam int unsigned CA_STOP_COUNT = 3;
   localparam int unsigned CA_SEND_BREAK = 2;
   localparam int unsigned CA_NINTH_BIT = 0;
   // uart_control_b fields
   localparam int unsigned CB_TRANSMIT_ENABLE = 7;
   localparam int unsigned CB_RECEIVE_ENABLE = 6;
   localparam int unsigned CB_ADDRESS_DETECT = 4;
   localparam int unsigned CB_WAKE_ENABLE = 3;
   localparam int unsigned CB_RECEIVE_IRQ = 2;
   localparam int unsigned CB_IDLE_IRQ = 1;
   localparam int unsigned CB_EMPTY_IRQ = 0;
   // bit timing in baud ticks, frame and break lengths in bits, buffer depth
   localparam logic [3:0] PHASE_LAST = 4'hF;
   localparam logic [3:0] VOTE_FIRST = 4'h7;
   localparam logic [3:0] VOTE_LAST = 4'h9;
   localparam logic [3:0] FRAME_LAST_BASE = 4'h9;
   localparam logic [3:0] DATA_LAST_8 = 4'h7;
   localparam logic [3:0] DATA_LAST_9 = 4'h8;
   localparam logic [3:0] BREAK_LAST = 4'hC;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   typedef struct packed {
      logic parity_error_flag;
      logic noise_flag;
      logic framing_error_flag;
      logic overrun_flag;
      logic receiver_idle_flag;
      logic receive_full_flag;
      logic transmitter_idle_flag;
      logic transmit_empty_flag;
   } status_type;
   typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SHIFT = 3'b010, TX_BREAK = 3'b100} tx_state_type;
   typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100,
      RX_STOP = 4'b1000} rx_state_type;
endpackage

// *** verif/serial_peer.sv ***
// Purpose: far-side serial device for the port bench
// Assumes: divisor 0, so 16 clocks per bit
// Notes: undriven output pin is pulled high
`timescale 1ns/1ps
module serial_peer
(
   input wire logic clk_sys,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   output logic serial_in
);
   localparam int BIT = 16;
   logic line;
   logic [11:0] got;
   int n_got = 0;
   // floating pin reads the pull-up level
   assign line = serial_out_oe ? serial_out : 1'b1;
   initial serial_in = 1'b1;
   // start, data lsb first, stop_count_select, then idle high
   task automatic send(input logic [11:0] f);
      for (int i = 0; i < 12; i++) begin
         serial_in <= f[i];
         repeat (BIT) @(posedge clk_sys);
      end
   endtask
   // sample twelve bit centres from the start edge
   always @(negedge line) begin
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 12; i++) begin
         got[i] = line;
         if (i < 11) repeat (BIT) @(posedge clk_sys);
      end
      n_got++;
   end
endmodule // serial_peer

// *** verif/tb_uart_serial_port.sv ***
// Purpose: self-checking bench for the serial port
// Assumes: divisor 0, peer model on the serial pins
// Notes: random data from a fixed xorshift seed
`timescale 1ns/1ps
module tb_uart_serial_port
   import uart_serial_port_pkg::*;
;
   logic clk_sys, reset, psel, penable, pwrite, er;
   logic [7:0] paddr, ca, cb, st;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, serial_in, serial_out, serial_out_oe, uart_irq;
   logic [31:0] seed = 32'h55C4502B;
   logic [8:0] d;
   logic [11:0] f, flip;
   logic [7:0] txcfg [5] = '{8'h80, 8'hA0, 8'hB8, 8'hC1, 8'hC0};
   // control_a, control_b, frame flips, expected status
   logic [35:0] rows [8] = '{36'h80C00000F, 36'hA0C01008F, 36'hB0C00000F, 36'h90C01000F,
      36'h80C02002F, 36'hC0C00000F, 36'h80D40000B, 36'h80D41000F};
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int t;
   uart_serial_port dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .uart_irq(uart_irq));
   serial_peer peer (.clk_sys(clk_sys), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .serial_in(serial_in));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // wire pattern of one frame, idle high after it
   function automatic logic [11:0] exp_frame(input logic [8:0] dv, input logic [7:0] c);
      logic [11:0] fr;
      logic p;
      int n;
      n = c[6] ? 9 : 8;
      fr = 12'hFFE;
      p = c[4];
      for (int i = 0; i < n; i++) begin
         fr[i + 1] = dv[i];
         if (i < n - 1) p = p ^ dv[i];
      end
      if (c[5]) fr[n] = p;
      return fr;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task results();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 8'h00);
      chk(rd, e);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      reset = 1'b1;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      rdchk(ADDR_STATUS, 32'h0B);
      rdchk(ADDR_CONTROL_B, 32'h0);
      apb(1'b1, ADDR_STATUS, 8'hF4);
      rdchk(ADDR_STATUS, 32'h0B);
      ca = 8'(rnd());
      apb(1'b1, ADDR_BAUD, ca);
      rdchk(ADDR_BAUD, {24'h0, ca});
      apb(1'b1, ADDR_BAUD, 8'h00);
      rdchk(8'h14, 32'h0);
      chk(32'(er), 32'h1);
      apb(1'b1, ADDR_CONTROL_A, 8'h80);
      apb(1'b1, ADDR_CONTROL_B, 8'hC0);
      rdchk(ADDR_STATUS, 32'h0B);
      chk(serial_out_oe, 32'h1);
      $display("register checks done");
      foreach (txcfg[i]) begin
         ca = txcfg[i];
         d = {ca[0], 8'(rnd())};
         apb(1'b1, ADDR_CONTROL_A, ca);
         rdchk(ADDR_STATUS, 32'h0B);
         t = peer.n_got;
         apb(1'b1, ADDR_DATA, d[7:0]);
         apb(1'b0, ADDR_STATUS, 8'h00);
         chk(rd & 32'h2, 32'h0);
         repeat (400) if (peer.n_got == t) @(posedge clk_sys);
         chk(peer.got, exp_frame(d, ca));
      end
      $display("transmit checks done");
      foreach (rows[i]) begin
         {ca, cb, flip, st} = rows[i];
         apb(1'b1, ADDR_CONTROL_A, ca);
         apb(1'b1, ADDR_CONTROL_B, cb);
         d = 9'(rnd()) & 9'h17F;
         f = exp_frame(d, ca) ^ flip;
         fork
            peer.send(f);
            begin
               repeat (60) @(posedge clk_sys);
               apb(1'b0, ADDR_STATUS, 8'h00);
               chk(rd & 32'h8, 32'h0);
            end
         join
         rdchk(ADDR_STATUS, {24'h0, st});
         chk(uart_irq, st[2] & cb[2]);
         if (st[2]) begin
            if (ca[6]) rdchk(ADDR_CONTROL_A, {ca[7:2], f[9], 1'b0});
            apb(1'b0, ADDR_DATA, 8'h00);
            chk(rd & (ca[5] ? 32'h7F : 32'hFF), f[8:1] & (ca[5] ? 8'h7F : 8'hFF));
         end
         rdchk(ADDR_STATUS, 32'h0B);
      end
      $display("receive checks done");
      apb(1'b1, ADDR_CONTROL_A, 8'h80);
      apb(1'b1, ADDR_CONTROL_B, 8'hC0);
      for (int i = 0; i < 3; i++) peer.send(exp_frame(9'(8'h41 + i), 8'h80));
      rdchk(ADDR_STATUS, 32'h1F);
      rdchk(ADDR_DATA, 32'h41);
      rdchk(ADDR_STATUS, 32'h0F);
      rdchk(ADDR_DATA, 32'h42);
      rdchk(ADDR_STATUS, 32'h0B);
      peer.send(exp_frame(9'h055, 8'h80));
      apb(1'b1, ADDR_CONTROL_B, 8'h40);
      rdchk(ADDR_CONTROL_B, 32'h40);
      chk(serial_out_oe, 32'h0);
      apb(1'b1, ADDR_CONTROL_A, 8'h00);
      rdchk(ADDR_CONTROL_B, 32'h0);
      rdchk(ADDR_STATUS, 32'h0B);
      $display("overrun and disable checks done");
      results();
   end
endmodule // tb_uart_serial_port
